/* logic/arith_datapath_cfg.svh */
// Constants of the arithmetic register datapath
// Assumes inclusion by bare name from the package and the design files
`ifndef ARITH_DATAPATH_CFG_SVH
`define ARITH_DATAPATH_CFG_SVH
`define WORD_W        48
`define EXP_LO        36
`define EXP_HI        46
`define EXP_W         11
`define ADDR_W        15
`define STEP_W        15
`define OP_SEL_SUB    6'h23
`define OP_MASK_EQ    6'h36
`define OP_MASK_THR   6'h37
`define WORD_RST      48'h000000000000
`endif

/* logic/arith_datapath_pkg.sv */
// Types of the arithmetic register datapath
// Assumes the cfg header is on the include path
`include "arith_datapath_cfg.svh"
package arith_datapath_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef enum logic [1:0] {
    SH_NONE,
    SH_LEFT,
    SH_RIGHT
  } shift_dir_t;
endpackage

/* logic/step_counter.sv */
// Step-control count for multiply, divide and shift
// Assumes one-cycle load and decrement strobes from the sequencer
`timescale 1ns/1ps
`include "arith_datapath_cfg.svh"
module step_counter #(
  parameter int W = `STEP_W
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  output logic [W-1:0]      count,
  output logic              done
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (dec && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign count = cnt_ff;
  assign done  = (cnt_ff == '0);

  a_count_dec: assert property (@(posedge clk) disable iff (!nrst)
    dec && !load && cnt_ff != '0 |=> cnt_ff == $past(cnt_ff) - W'(1))
    else $error("step count did not decrease by one");
endmodule

/* logic/arith_register_datapath.sv */
// Accumulator, auxiliary and exchange register datapath
// Assumes a control sequencer issuing one-cycle command strobes on clk
`timescale 1ns/1ps
`include "arith_datapath_cfg.svh"
module arith_register_datapath #(
  parameter int W = `WORD_W
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Accumulator commands
  input  wire logic                        acc_load_mem,
  input  wire arith_datapath_pkg::word_t   mem_word,
  input  wire logic                        acc_add_x,
  input  wire logic                        acc_sub_x,
  input  wire logic                        acc_rank_fwd,
  input  wire logic                        acc_from_aux,
  input  wire logic                        sel_substitute,
  input  wire arith_datapath_pkg::shift_dir_t shift_dir,
  input  wire logic                        shift_paired,
  // Auxiliary commands
  input  wire logic                        aux_from_acc,
  input  wire logic                        aux_rank_up,
  input  wire logic                        aux_rank_down,
  // Exchange commands
  input  wire logic                        x_from_acc,
  input  wire logic                        x_from_mem,
  input  wire logic                        x_from_input,
  input  wire arith_datapath_pkg::word_t   input_word,
  input  wire logic                        x_exp_load,
  input  wire logic [`EXP_W-1:0]           exp_result,
  input  wire logic                        x_addr_load,
  input  wire logic [`ADDR_W-1:0]          mod_addr,
  input  wire logic                        x_logical_product,
  input  wire logic                        fetch_next_word_sequence,
  input  wire logic                        x_rank_fwd,
  input  wire logic                        ret_jump,
  input  wire logic [`ADDR_W-1:0]          program_counter_rank,
  // Step control
  input  wire logic                        step_load,
  input  wire logic [`STEP_W-1:0]          step_val,
  input  wire logic                        step_from_x,
  input  wire logic                        step_dec,
  // Outputs
  output arith_datapath_pkg::word_t        accumulator,
  output arith_datapath_pkg::word_t        aux_first_rank,
  output arith_datapath_pkg::word_t        aux_second_rank,
  output arith_datapath_pkg::word_t        exchange_input_rank,
  output arith_datapath_pkg::word_t        exchange_output_rank,
  output arith_datapath_pkg::word_t        store_word,
  output arith_datapath_pkg::word_t        search_mask,
  output logic [`EXP_W-1:0]                exponent_subtractive_accumulator,
  output logic [`STEP_W-1:0]               step_control_rank,
  output logic                             step_done
);
  import arith_datapath_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  word_t acc1_ff;
  word_t acc2_ff;
  word_t aux1_ff;
  word_t aux2_ff;
  word_t x1_ff;
  word_t x2_ff;
  logic [`EXP_W-1:0] exp_ff;
  word_t nxt_acc1;
  word_t nxt_aux2;
  logic  step_src;
  logic [`STEP_W-1:0] step_in;
  logic  x_idle;

  // ----------------------------------------------------------------
  // Shift helpers
  // ----------------------------------------------------------------
  function automatic word_t rot_left(input word_t v);
    rot_left = {v[W-2:0], v[W-1]};
  endfunction

  function automatic word_t ext_right(input word_t v);
    ext_right = {v[W-1], v[W-1:1]};
  endfunction

  // ----------------------------------------------------------------
  // Accumulator and auxiliary next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_acc1 = acc1_ff;
    nxt_aux2 = aux2_ff;
    if (shift_dir == SH_LEFT && shift_paired) begin
      // 96-bit circular left
      nxt_acc1 = {acc1_ff[W-2:0], aux2_ff[W-1]};
      nxt_aux2 = {aux2_ff[W-2:0], acc1_ff[W-1]};
    end else if (shift_dir == SH_RIGHT && shift_paired) begin
      nxt_acc1 = ext_right(acc1_ff);
      nxt_aux2 = {acc1_ff[0], aux2_ff[W-1:1]};
    end else if (shift_dir == SH_LEFT) begin
      nxt_acc1 = rot_left(acc1_ff);
    end else if (shift_dir == SH_RIGHT) begin
      nxt_acc1 = ext_right(acc1_ff);
    end else if (acc_load_mem) begin
      nxt_acc1 = mem_word;
    end else if (acc_add_x) begin
      nxt_acc1 = acc1_ff + x2_ff;
    end else if (acc_sub_x) begin
      nxt_acc1 = acc1_ff - x2_ff;
    end else if (sel_substitute) begin
      nxt_acc1 = (acc1_ff & ~aux1_ff) | (mem_word & aux1_ff);
    end else if (acc_from_aux) begin
      nxt_acc1 = aux2_ff;
    end
    if (aux_rank_down) begin
      nxt_aux2 = aux1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator ranks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc1_ff <= `WORD_RST;
    end else begin
      acc1_ff <= nxt_acc1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc2_ff <= `WORD_RST;
    end else if (acc_rank_fwd) begin
      acc2_ff <= acc1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary ranks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aux1_ff <= `WORD_RST;
    end else if (aux_from_acc) begin
      aux1_ff <= acc2_ff;
    end else if (aux_rank_up) begin
      aux1_ff <= aux2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aux2_ff <= `WORD_RST;
    end else begin
      aux2_ff <= nxt_aux2;
    end
  end

  // ----------------------------------------------------------------
  // Exchange input rank, no instruction path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      x1_ff <= `WORD_RST;
    end else if (fetch_next_word_sequence) begin
      x1_ff <= `WORD_RST;
    end else if (x_from_acc) begin
      x1_ff <= `WORD_RST | acc1_ff;
    end else if (x_from_mem) begin
      x1_ff <= `WORD_RST | mem_word;
    end else if (x_from_input) begin
      x1_ff <= `WORD_RST | input_word;
    end else if (x_exp_load) begin
      x1_ff <= word_t'(exp_result) << `EXP_LO;
    end else if (x_addr_load) begin
      x1_ff <= {{(W-`ADDR_W){1'b0}}, mod_addr};
    end else if (x_logical_product) begin
      x1_ff <= aux1_ff & x2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Exchange output rank
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      x2_ff <= `WORD_RST;
    end else if (ret_jump) begin
      x2_ff <= {{(W-`ADDR_W){1'b0}}, program_counter_rank + `ADDR_W'(1)};
    end else if (x_rank_fwd) begin
      x2_ff <= x1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Exponent unit
  // ----------------------------------------------------------------
  assign x_idle = !(step_from_x | x_rank_fwd | x_from_mem | x_addr_load | x_from_acc
                    | x_exp_load | ret_jump | fetch_next_word_sequence
                    | x_logical_product | x_from_input);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      exp_ff <= '0;
    end else if (x_exp_load) begin
      exp_ff <= exp_ff;
    end else if (x_idle) begin
      exp_ff <= x1_ff[`EXP_HI:`EXP_LO];
    end
  end

  // ----------------------------------------------------------------
  // Step control
  // ----------------------------------------------------------------
  assign step_src = step_load | step_from_x;
  assign step_in  = step_from_x ? x1_ff[`STEP_W-1:0] : step_val;

  step_counter #(.W(`STEP_W)) u_step (
    .clk      (clk),
    .nrst     (nrst),
    .load     (step_src),
    .load_val (step_in),
    .dec      (step_dec),
    .count    (step_control_rank),
    .done     (step_done)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign accumulator                      = acc1_ff;
  assign aux_first_rank                   = aux1_ff;
  assign aux_second_rank                  = aux2_ff;
  assign exchange_input_rank              = x1_ff;
  assign exchange_output_rank             = x2_ff;
  assign store_word                       = x1_ff;
  assign search_mask                      = aux1_ff;
  assign exponent_subtractive_accumulator = exp_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rot_left: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_LEFT && !shift_paired |=> acc1_ff == rot_left($past(acc1_ff)))
    else $error("accumulator left shift not circular");
  a_ext_right: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_RIGHT && !shift_paired |=> acc1_ff == ext_right($past(acc1_ff)))
    else $error("accumulator right shift lost sign");
  a_pair_right: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_RIGHT && shift_paired && !aux_rank_down
    |=> aux2_ff[W-1] == $past(acc1_ff[0]))
    else $error("paired right shift bit not in auxiliary top");
  a_pair_left: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_LEFT && shift_paired && !aux_rank_down
    |=> aux2_ff[0] == $past(acc1_ff[W-1]) && acc1_ff[0] == $past(aux2_ff[W-1]))
    else $error("paired left shift bit lost");
  a_aux_dup: assert property (@(posedge clk) disable iff (!nrst)
    aux_from_acc |=> aux1_ff == $past(acc2_ff))
    else $error("auxiliary did not duplicate accumulator");
  a_x_clear: assert property (@(posedge clk) disable iff (!nrst)
    fetch_next_word_sequence |=> x1_ff == `WORD_RST)
    else $error("exchange input rank not cleared");
  a_x_cleared_load: assert property (@(posedge clk) disable iff (!nrst)
    x_from_mem && !fetch_next_word_sequence && !x_from_acc |=> x1_ff == $past(mem_word))
    else $error("exchange load kept stale ones");
  a_ret_jump: assert property (@(posedge clk) disable iff (!nrst)
    ret_jump |=> x2_ff[`ADDR_W-1:0] == $past(program_counter_rank) + `ADDR_W'(1))
    else $error("return address not forced");
  a_sel_sub: assert property (@(posedge clk) disable iff (!nrst)
    sel_substitute && shift_dir == SH_NONE && !acc_load_mem && !acc_add_x && !acc_sub_x
    |=> acc1_ff == (($past(acc1_ff) & ~$past(aux1_ff)) | ($past(mem_word) & $past(aux1_ff))))
    else $error("selective substitute wrong");
  a_pair_racc: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_RIGHT && shift_paired |=> acc1_ff == ext_right($past(acc1_ff)))
    else $error("paired right shift lost accumulator sign");
  a_aux_hold: assert property (@(posedge clk) disable iff (!nrst)
    !aux_from_acc && !aux_rank_up |=> aux1_ff == $past(aux1_ff))
    else $error("auxiliary first rank moved without command");
  a_aux_up: assert property (@(posedge clk) disable iff (!nrst)
    aux_rank_up && !aux_from_acc |=> aux1_ff == $past(aux2_ff))
    else $error("auxiliary rank transfer up wrong");
  a_aux2_hold: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_NONE && !aux_rank_down |=> aux2_ff == $past(aux2_ff))
    else $error("auxiliary second rank moved without command");
  a_acc2_fwd: assert property (@(posedge clk) disable iff (!nrst)
    acc_rank_fwd |=> acc2_ff == $past(acc1_ff))
    else $error("accumulator rank transfer wrong");
  a_store_aux: assert property (@(posedge clk) disable iff (!nrst)
    acc_from_aux && shift_dir == SH_NONE && !acc_load_mem && !acc_add_x && !acc_sub_x
    && !sel_substitute |=> acc1_ff == $past(aux2_ff))
    else $error("auxiliary word not routed to accumulator");
  a_add_augend: assert property (@(posedge clk) disable iff (!nrst)
    acc_add_x && shift_dir == SH_NONE && !acc_load_mem
    |=> acc1_ff == $past(acc1_ff) + $past(x2_ff))
    else $error("adder did not take exchange output rank");
  a_sub_operand: assert property (@(posedge clk) disable iff (!nrst)
    acc_sub_x && shift_dir == SH_NONE && !acc_load_mem && !acc_add_x
    |=> acc1_ff == $past(acc1_ff) - $past(x2_ff))
    else $error("subtrahend not taken from exchange");
  a_acc_hold: assert property (@(posedge clk) disable iff (!nrst)
    shift_dir == SH_NONE && !acc_load_mem && !acc_add_x && !acc_sub_x && !sel_substitute
    && !acc_from_aux |=> acc1_ff == $past(acc1_ff))
    else $error("accumulator moved without command");
  a_x_exp_field: assert property (@(posedge clk) disable iff (!nrst)
    x_exp_load && !fetch_next_word_sequence && !x_from_acc && !x_from_mem && !x_from_input
    |=> x1_ff == word_t'($past(exp_result)) << `EXP_LO)
    else $error("exponent field not placed in exchange");
  a_x_addr_low: assert property (@(posedge clk) disable iff (!nrst)
    x_addr_load && !x_exp_load && !fetch_next_word_sequence && !x_from_acc && !x_from_mem
    && !x_from_input |=> x1_ff == word_t'($past(mod_addr)))
    else $error("address not placed in exchange low bits");
  a_x_and: assert property (@(posedge clk) disable iff (!nrst)
    x_logical_product && !x_addr_load && !x_exp_load && !fetch_next_word_sequence
    && !x_from_acc && !x_from_mem && !x_from_input
    |=> x1_ff == ($past(aux1_ff) & $past(x2_ff)))
    else $error("logical product wrong");
  a_x_only_cmds: assert property (@(posedge clk) disable iff (!nrst)
    !x_logical_product && !x_addr_load && !x_exp_load && !fetch_next_word_sequence
    && !x_from_acc && !x_from_mem && !x_from_input |=> x1_ff == $past(x1_ff))
    else $error("exchange input rank moved without command");
  a_x2_fwd: assert property (@(posedge clk) disable iff (!nrst)
    x_rank_fwd && !ret_jump |=> x2_ff == $past(x1_ff))
    else $error("exchange rank transfer wrong");
  a_exp_take: assert property (@(posedge clk) disable iff (!nrst)
    x_idle |=> exp_ff == $past(x1_ff[`EXP_HI:`EXP_LO]))
    else $error("exponent field not taken");
  a_exp_hold: assert property (@(posedge clk) disable iff (!nrst)
    x_exp_load |=> exp_ff == $past(exp_ff))
    else $error("exponent unit changed during result assembly");
  a_step_from_x: assert property (@(posedge clk) disable iff (!nrst)
    step_from_x |=> step_control_rank == $past(x1_ff[`STEP_W-1:0]))
    else $error("step count not taken from exchange");
  a_step_load: assert property (@(posedge clk) disable iff (!nrst)
    step_load && !step_from_x |=> step_control_rank == $past(step_val))
    else $error("step count not loaded");
endmodule

/* sim/core_storage_model.sv */
// Behavioural core storage beyond the exchange register
// Assumes one-cycle read and write strobes from the sequencer on clk
`timescale 1ns/1ps
module core_storage_model (
  input  wire logic                      clk,
  input  wire logic                      rd,
  input  wire logic                      wr,
  input  wire logic [3:0]                addr,
  input  wire arith_datapath_pkg::word_t wdata,
  output arith_datapath_pkg::word_t      rdata
);
  import arith_datapath_pkg::*;
  word_t mem_ff [16];
  word_t junk_ff = 48'h5A5A_F0F0_3C3C;
  // Word on the lines only while a read is commanded
  assign rdata = rd ? mem_ff[addr] : junk_ff;
  always @(posedge clk) begin
    junk_ff <= {junk_ff[46:0], ~junk_ff[47]};
  end
  always @(posedge clk) begin
    if (wr) begin
      mem_ff[addr] <= wdata;
    end
  end
endmodule

/* sim/arith_register_datapath_tb.sv */
// Self-checking bench for the arithmetic register datapath
// Assumes the design files and core_storage_model are compiled first
`timescale 1ns/1ps
`include "arith_datapath_cfg.svh"
module arith_register_datapath_tb;
  import arith_datapath_pkg::*;
  localparam int LDM = 0, ADD = 1, SBX = 2, AFQ = 3, SUB = 4, SHL = 5, SHR = 6, PSL = 7;
  localparam int PSR = 8, AFA = 9, ARU = 10, ARD = 11, XFA = 12, XFM = 13, XIN = 14;
  localparam int XEL = 15, XAL = 16, XLP = 17, FNW = 18, XRF = 19, RJ = 20, SLD = 21;
  localparam int SFX = 22, SDC = 23, MWR = 24, ARF = 25, NOP = 26;
  logic clk = 1'b0;
  logic nrst;
  logic acc_load_mem, acc_add_x, acc_sub_x, acc_rank_fwd, acc_from_aux, sel_substitute;
  logic shift_paired, aux_from_acc, aux_rank_up, aux_rank_down, x_from_acc, x_from_mem;
  logic x_from_input, x_exp_load, x_addr_load, x_logical_product, fetch_next_word_sequence;
  logic x_rank_fwd, ret_jump, step_load, step_from_x, step_dec, mem_wr, step_done;
  shift_dir_t shift_dir;
  word_t mem_word, input_word, accumulator, aux_first_rank, aux_second_rank;
  word_t exchange_input_rank, exchange_output_rank, store_word, search_mask;
  logic [`EXP_W-1:0] exp_result, exponent_subtractive_accumulator, e;
  logic [`ADDR_W-1:0] mod_addr, program_counter_rank, step_val, step_control_rank, m;
  logic [3:0] mem_addr;
  wire mem_rd = acc_load_mem | x_from_mem | sel_substitute;
  int q_sel[$];
  word_t q_exp[$];
  int errors = 0;
  int compares = 0;
  word_t w [3];
  word_t ea, eq1, eq2, ex1, ex2;
  logic [95:0] p;

  arith_register_datapath i_dut (.*);
  core_storage_model i_store (
    .clk   (clk),
    .rd    (mem_rd),
    .wr    (mem_wr),
    .addr  (mem_addr),
    .wdata (store_word),
    .rdata (mem_word)
  );
  always #4 clk = ~clk;

  // --------------------------------
  // Drivers and comparison
  // --------------------------------
  task automatic clr();
    {acc_load_mem, acc_add_x, acc_sub_x, acc_rank_fwd, acc_from_aux, sel_substitute} <= '0;
    {shift_paired, aux_from_acc, aux_rank_up, aux_rank_down, x_from_acc, x_from_mem} <= '0;
    {x_from_input, x_exp_load, x_addr_load, x_logical_product, fetch_next_word_sequence} <= '0;
    {x_rank_fwd, ret_jump, step_load, step_from_x, step_dec, mem_wr} <= '0;
    shift_dir <= SH_NONE;
  endtask
  task automatic cmd(input int c);
    @(posedge clk);
    shift_paired <= (c == PSL || c == PSR);
    case (c)
      LDM: acc_load_mem <= 1'b1;
      ADD: acc_add_x <= 1'b1;
      SBX: acc_sub_x <= 1'b1;
      AFQ: acc_from_aux <= 1'b1;
      SUB: sel_substitute <= 1'b1;
      SHL, PSL: shift_dir <= SH_LEFT;
      SHR, PSR: shift_dir <= SH_RIGHT;
      AFA: aux_from_acc <= 1'b1;
      ARU: aux_rank_up <= 1'b1;
      ARD: aux_rank_down <= 1'b1;
      XFA: x_from_acc <= 1'b1;
      XFM: x_from_mem <= 1'b1;
      XIN: x_from_input <= 1'b1;
      XEL: x_exp_load <= 1'b1;
      XAL: x_addr_load <= 1'b1;
      XLP: x_logical_product <= 1'b1;
      FNW: fetch_next_word_sequence <= 1'b1;
      XRF: x_rank_fwd <= 1'b1;
      RJ: ret_jump <= 1'b1;
      SLD: step_load <= 1'b1;
      SFX: step_from_x <= 1'b1;
      SDC: step_dec <= 1'b1;
      MWR: mem_wr <= 1'b1;
      ARF: acc_rank_fwd <= 1'b1;
      default: ;
    endcase
    @(posedge clk);
    clr();
  endtask
  task automatic note(input int s, input word_t v);
    q_sel.push_back(s);
    q_exp.push_back(v);
  endtask
  function automatic word_t pick(input int s);
    case (s)
      0: return accumulator;
      1: return aux_first_rank;
      2: return aux_second_rank;
      3: return exchange_input_rank;
      4: return exchange_output_rank;
      5: return store_word;
      6: return search_mask;
      7: return word_t'(exponent_subtractive_accumulator);
      8: return word_t'(step_control_rank);
      default: return word_t'(step_done);
    endcase
  endfunction
  task automatic check(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(negedge clk);
      while (q_sel.size() > 0) begin
        check(pick(q_sel.pop_front()), q_exp.pop_front());
      end
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    summarize();
  end

  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    void'($urandom(32'h55B4));
    clr();
    nrst <= 1'b0;
    {input_word, exp_result, mod_addr, program_counter_rank, step_val, mem_addr} <= '0;
    repeat (4) @(posedge clk);
    note(0, '0);
    note(9, 48'h1);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      w[i] = word_t'({$urandom(), $urandom()});
      w[i][47] = (i == 0);
      input_word <= w[i];
      cmd(XIN);
      note(3, w[i]);
      mem_addr <= i[3:0];
      cmd(MWR);
    end
    cmd(FNW);
    note(3, '0);
    mem_addr <= 4'h0;
    cmd(LDM);
    ea = w[0];
    for (int i = 0; i < 8; i++) begin
      if (i > 0 && $urandom_range(1) == 1) begin
        cmd(SHL);
        ea = {ea[46:0], ea[47]};
      end else begin
        cmd(SHR);
        ea = {ea[47], ea[47:1]};
      end
      note(0, ea);
    end
    cmd(ARF);
    cmd(AFA);
    eq1 = ea;
    note(1, eq1);
    note(6, eq1);
    cmd(ARD);
    eq2 = eq1;
    note(2, eq2);
    mem_addr <= 4'h1;
    cmd(LDM);
    ea = w[1];
    cmd(AFA);
    note(2, eq2);
    cmd(ARU);
    eq1 = eq2;
    note(1, eq1);
    for (int i = 0; i < 6; i++) begin
      p = {ea, eq2};
      if (i[0]) begin
        cmd(PSL);
        p = {p[94:0], p[95]};
      end else begin
        cmd(PSR);
        p = {p[95], p[95:1]};
      end
      {ea, eq2} = p;
      note(0, ea);
      note(2, eq2);
    end
    cmd(ARF);
    cmd(AFA);
    cmd(ARD);
    eq1 = ea;
    eq2 = ea;
    mem_addr <= 4'h2;
    cmd(LDM);
    mem_addr <= 4'h1;
    cmd(SUB);
    ea = (w[2] & ~eq1) | (w[1] & eq1);
    note(0, ea);
    cmd(XFA);
    ex1 = ea;
    cmd(XRF);
    note(4, ex1);
    cmd(ADD);
    ea = ea + ex1;
    note(0, ea);
    cmd(SBX);
    ea = ea - ex1;
    note(0, ea);
    cmd(XLP);
    note(3, eq1 & ex1);
    m = 15'($urandom_range(32766));
    program_counter_rank <= m;
    cmd(RJ);
    note(4, word_t'(m) + 48'h1);
    e = 11'($urandom());
    exp_result <= e;
    cmd(XEL);
    note(3, word_t'(e) << `EXP_LO);
    cmd(NOP);
    note(7, word_t'(e));
    m = 15'($urandom());
    mod_addr <= m;
    cmd(XAL);
    note(3, word_t'(m));
    cmd(SFX);
    note(8, word_t'(m));
    step_val <= 15'h3;
    cmd(SLD);
    note(9, '0);
    for (int i = 2; i >= -1; i--) begin
      cmd(SDC);
      note(8, word_t'(i < 0 ? 0 : i));
    end
    note(9, 48'h1);
    cmd(ARF);
    cmd(ARD);
    cmd(AFQ);
    cmd(XFA);
    note(5, eq1);
    note(1, eq1);
    mem_addr <= 4'h3;
    cmd(MWR);
    cmd(XFM);
    note(3, eq1);
    cmd(NOP);
    summarize();
  end
endmodule
